// [rtl/cmx_consts.vh]
// constants for the cursor and memory extension register bank
// assumes inclusion by rtl/cmx_regs.v only
`ifndef CMX_CONSTS_VH
`define CMX_CONSTS_VH
// ****************************************
// register indices
// ****************************************
`define CMX_IDX_MODE     8'h45
`define CMX_IDX_ORGX_H   8'h46
`define CMX_IDX_ORGX_L   8'h47
`define CMX_IDX_ORGY_H   8'h48
`define CMX_IDX_ORGY_L   8'h49
`define CMX_IDX_FGSTK    8'h4A
`define CMX_IDX_BGSTK    8'h4B
`define CMX_IDX_STA_H    8'h4C
`define CMX_IDX_STA_L    8'h4D
`define CMX_IDX_DX       8'h4E
`define CMX_IDX_DY       8'h4F
`define CMX_IDX_SCTL2    8'h51
`define CMX_IDX_BFLG     8'h52
`define CMX_IDX_MCTL1    8'h53
`define CMX_IDX_MCTL2    8'h54
// ****************************************
// writable masks and reset values
// ****************************************
`define CMX_MSK_MODE     8'h13
`define CMX_MSK_HI3      8'h07
`define CMX_MSK_HI4      8'h0F
`define CMX_MSK_SKIP     8'h3F
`define CMX_MSK_SCTL2    8'h7F
`define CMX_MSK_MCTL1    8'h7F
`define CMX_MSK_MCTL2    8'h03
`define CMX_RST_ZERO     8'h00
`define CMX_RST_MCTL1    8'h08
// ****************************************
// field positions and codes
// ****************************************
`define CMX_BIT_ENB      0
`define CMX_BIT_CDE      1
`define CMX_BIT_RIGHT    4
`define CMX_BIT_SPLIT    6
`define CMX_BIT_ALPHA    0
`define CMX_BIT_WIN      5
`define CMX_BIT_NIBBLE   6
`define CMX_SWP_NONE     2'h0
`define CMX_SWP_WORD     2'h1
`define CMX_SWP_DWORD    2'h2
`define CMX_SWP_BE       2'h3
`define CMX_MMIO_LEGACY  2'h2
`define CMX_MMIO_BOTH    2'h3
`define CMX_BE_ALL       4'h0
`define CMX_BE_LOW       4'h3
`define CMX_BE_HIGH      4'hC
`define CMX_LAW_2MB      2'h2
`endif

// [rtl/cmx_regs.v]
// indexed register bank for graphics cursor and extended memory control
// assumes index/data port decode upstream; inputs are synchronous to i_clk
// Summary of operation
// [RULE1] delay extension bit is bit 3 of cursor fetch delay, low bits from sequencer
// [RULE2] right storage uses last 256 of 1K line at 4bpp, 512 of 2K at 8bpp
// [RULE3] software sets storage start low bits to 11 in right-storage mode
// [RULE4] left x is 11 bits, high three then low byte, upper bits reserved
// [RULE5] top y 11 bits; x and y position commit on y high write
// [RULE6] foreground stack of three bytes, write at pointer then advance
// [RULE7] background stack of three bytes shares the same pointer
// [RULE8] reading the cursor mode register clears the stack pointer
// [RULE9] storage start is 12 bits, high four then low byte
// [RULE10] six-bit horizontal pattern skip for partial cursor at left
// [RULE11] six-bit vertical pattern skip for partial cursor at top
// [RULE12] display start bits 19-18, ignored when extension register is used
// [RULE13] cpu base bits 19-18, ignored when extension register is used
// [RULE14] screen width bits 9-8; nonzero overrides the older width bit 8
// [RULE15] split transfer off bit suppresses split memory transfers
// [RULE16] software keeps split transfers enabled in enhanced modes
// [RULE17] bios flag byte is scratch, resets to zero
// [RULE18] alpha pitch only with linear addressing and window of 2MB or more
// [RULE19] linear swap 00 none, 01 word, 10 dword, 11 reserved
// [RULE20] mapped io select 00 off, 01 relocatable, 10 legacy, 11 both
// [RULE21] legacy window at A8000 or B8000, effective only at select 10
// [RULE22] nibble swap exchanges nibbles of bytes in linear accesses
// [RULE23] non-linear swap uses same codes; 11 follows byte enables
// [RULE24] byte enables 0000 reverse dword, 0011 or 1100 swap word, else none
// [RULE25] enable bit turns cursor on in enhanced modes only
// [RULE26] reserved bits read zero and ignore writes
`include "cmx_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module cmx_regs
(
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire [7:0]  i_index,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire [7:0]  i_wdata,
  input  wire [2:0]  i_seq_delay_lo,
  input  wire        i_enhanced_mode,
  input  wire        i_bpp8,
  input  wire        i_disp_start_ext_used,
  input  wire        i_cpu_base_ext_used,
  input  wire        i_old_width_bit8,
  input  wire        i_linear_en,
  input  wire [1:0]  i_law_size,
  input  wire        i_linear_access,
  input  wire        i_image_access,
  input  wire [3:0]  i_pci_be_n,
  input  wire [31:0] i_mem_data,
  output reg  [7:0]  o_rdata,
  output reg         o_cursor_on,
  output reg  [3:0]  o_cursor_delay,
  output reg         o_right_storage,
  output reg         o_right_2k_line,
  output reg  [10:0] o_cursor_left_x,
  output reg  [10:0] o_cursor_top_y,
  output reg  [23:0] o_fg_color,
  output reg  [23:0] o_bg_color,
  output reg  [11:0] o_cursor_store_base,
  output reg  [5:0]  o_pattern_skip_x,
  output reg  [5:0]  o_pattern_skip_y,
  output reg  [1:0]  o_display_start_hi,
  output reg  [1:0]  o_cpu_base_hi,
  output reg  [9:8]  o_screen_width_hi,
  output reg         o_split_transfer_off,
  output reg         o_alpha_pitch_active,
  output reg         o_mmio_reloc_en,
  output reg         o_mmio_legacy_en,
  output reg         o_legacy_window_high,
  output reg  [31:0] o_mem_data_swapped
);

  // ****************************************
  // swap function
  // ****************************************
  function [31:0] cmx_swap;
    input [1:0]  code;
    input [31:0] d;
    begin
      case (code)
        `CMX_SWP_WORD:  cmx_swap = {d[23:16], d[31:24], d[7:0], d[15:8]};
        `CMX_SWP_DWORD: cmx_swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
        default:        cmx_swap = d;
      endcase
    end
  endfunction

  // ****************************************
  // register storage
  // ****************************************
  reg [7:0]  mode_r;
  reg [7:0]  orgx_h_r;
  reg [7:0]  orgx_l_r;
  reg [7:0]  orgy_h_r;
  reg [7:0]  orgy_l_r;
  reg [7:0]  fg_r [0:2];
  reg [7:0]  bg_r [0:2];
  reg [1:0]  stk_ptr_r;
  reg [7:0]  sta_h_r;
  reg [7:0]  sta_l_r;
  reg [7:0]  dx_r;
  reg [7:0]  dy_r;
  reg [7:0]  sctl2_r;
  reg [7:0]  bflg_r;
  reg [7:0]  mctl1_r;
  reg [7:0]  mctl2_r;
  reg [1:0]  stk_ptr_nxt;
  reg [7:0]  rdata_nxt;
  reg [1:0]  swap_code;
  reg [31:0] swapped;
  wire       wr_fg;
  wire       wr_bg;
  integer    k;
  integer    j;

  assign wr_fg = i_wr && (i_index == `CMX_IDX_FGSTK);
  assign wr_bg = i_wr && (i_index == `CMX_IDX_BGSTK);

  // ****************************************
  // stack pointer
  // ****************************************
  always @*
  begin
    stk_ptr_nxt = stk_ptr_r;
    if (wr_fg || wr_bg)
    begin
      stk_ptr_nxt = (stk_ptr_r == 2'h2) ? 2'h0 : stk_ptr_r + 2'h1; // RULE6
    end
    if (i_rd && (i_index == `CMX_IDX_MODE))
    begin
      stk_ptr_nxt = 2'h0; // RULE8
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mode_r    <= `CMX_RST_ZERO;
      orgx_h_r  <= `CMX_RST_ZERO;
      orgx_l_r  <= `CMX_RST_ZERO;
      orgy_h_r  <= `CMX_RST_ZERO;
      orgy_l_r  <= `CMX_RST_ZERO;
      stk_ptr_r <= 2'h0;
      sta_h_r   <= `CMX_RST_ZERO;
      sta_l_r   <= `CMX_RST_ZERO;
      dx_r      <= `CMX_RST_ZERO;
      dy_r      <= `CMX_RST_ZERO;
      sctl2_r   <= `CMX_RST_ZERO;
      bflg_r    <= `CMX_RST_ZERO;
      mctl1_r   <= `CMX_RST_MCTL1;
      mctl2_r   <= `CMX_RST_ZERO;
      for (k = 0; k < 3; k = k + 1)
      begin
        fg_r[k] <= `CMX_RST_ZERO;
        bg_r[k] <= `CMX_RST_ZERO;
      end
    end
    else
    begin
      stk_ptr_r <= stk_ptr_nxt;
      if (wr_fg)
      begin
        fg_r[stk_ptr_r] <= i_wdata; // RULE6
      end
      if (wr_bg)
      begin
        bg_r[stk_ptr_r] <= i_wdata; // RULE7
      end
      if (i_wr)
      begin
        case (i_index)
          `CMX_IDX_MODE:   mode_r   <= i_wdata & `CMX_MSK_MODE; // RULE26
          `CMX_IDX_ORGX_H: orgx_h_r <= i_wdata & `CMX_MSK_HI3; // RULE4
          `CMX_IDX_ORGX_L: orgx_l_r <= i_wdata; // RULE4
          `CMX_IDX_ORGY_H: orgy_h_r <= i_wdata & `CMX_MSK_HI3; // RULE5
          `CMX_IDX_ORGY_L: orgy_l_r <= i_wdata; // RULE5
          `CMX_IDX_STA_H:  sta_h_r  <= i_wdata & `CMX_MSK_HI4; // RULE9
          `CMX_IDX_STA_L:  sta_l_r  <= i_wdata; // RULE9
          `CMX_IDX_DX:     dx_r     <= i_wdata & `CMX_MSK_SKIP; // RULE10
          `CMX_IDX_DY:     dy_r     <= i_wdata & `CMX_MSK_SKIP; // RULE11
          `CMX_IDX_SCTL2:  sctl2_r  <= i_wdata & `CMX_MSK_SCTL2; // RULE26
          `CMX_IDX_BFLG:   bflg_r   <= i_wdata; // RULE17
          `CMX_IDX_MCTL1:  mctl1_r  <= i_wdata & `CMX_MSK_MCTL1; // RULE26
          `CMX_IDX_MCTL2:  mctl2_r  <= i_wdata & `CMX_MSK_MCTL2; // RULE26
          default:         mctl2_r  <= mctl2_r;
        endcase
      end
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always @*
  begin
    case (i_index)
      `CMX_IDX_MODE:   rdata_nxt = mode_r;
      `CMX_IDX_ORGX_H: rdata_nxt = orgx_h_r;
      `CMX_IDX_ORGX_L: rdata_nxt = orgx_l_r;
      `CMX_IDX_ORGY_H: rdata_nxt = orgy_h_r;
      `CMX_IDX_ORGY_L: rdata_nxt = orgy_l_r;
      `CMX_IDX_FGSTK:  rdata_nxt = (stk_ptr_r == 2'h3) ? 8'h00 : fg_r[stk_ptr_r];
      `CMX_IDX_BGSTK:  rdata_nxt = (stk_ptr_r == 2'h3) ? 8'h00 : bg_r[stk_ptr_r];
      `CMX_IDX_STA_H:  rdata_nxt = sta_h_r;
      `CMX_IDX_STA_L:  rdata_nxt = sta_l_r;
      `CMX_IDX_DX:     rdata_nxt = dx_r;
      `CMX_IDX_DY:     rdata_nxt = dy_r;
      `CMX_IDX_SCTL2:  rdata_nxt = sctl2_r;
      `CMX_IDX_BFLG:   rdata_nxt = bflg_r;
      `CMX_IDX_MCTL1:  rdata_nxt = mctl1_r;
      `CMX_IDX_MCTL2:  rdata_nxt = mctl2_r;
      default:         rdata_nxt = 8'h00;
    endcase
  end

  // ****************************************
  // data swap selection
  // ****************************************
  always @*
  begin
    swap_code = `CMX_SWP_NONE;
    if (i_image_access)
    begin
      swap_code = `CMX_SWP_NONE; // RULE23
    end
    else if (i_linear_access)
    begin
      swap_code = (mctl1_r[2:1] == `CMX_SWP_BE) ? `CMX_SWP_NONE : mctl1_r[2:1]; // RULE19
    end
    else if (!i_image_access)
    begin
      if (mctl2_r[1:0] != `CMX_SWP_BE)
      begin
        swap_code = mctl2_r[1:0]; // RULE23
      end
      else if (i_pci_be_n == `CMX_BE_ALL)
      begin
        swap_code = `CMX_SWP_DWORD; // RULE24
      end
      else if ((i_pci_be_n == `CMX_BE_LOW) || (i_pci_be_n == `CMX_BE_HIGH))
      begin
        swap_code = `CMX_SWP_WORD; // RULE24
      end
    end
    swapped = cmx_swap(swap_code, i_mem_data);
    if (i_linear_access && !i_image_access && mctl1_r[`CMX_BIT_NIBBLE])
    begin
      for (j = 0; j < 4; j = j + 1)
      begin
        swapped[j*8 +: 8] = {swapped[j*8 +: 4], swapped[j*8+4 +: 4]}; // RULE22
      end
    end
  end

  // ****************************************
  // output registers
  // ****************************************
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata              <= 8'h00;
      o_cursor_on          <= 1'b0;
      o_cursor_delay       <= 4'h0;
      o_right_storage      <= 1'b0;
      o_right_2k_line      <= 1'b0;
      o_cursor_left_x      <= 11'h000;
      o_cursor_top_y       <= 11'h000;
      o_fg_color           <= 24'h000000;
      o_bg_color           <= 24'h000000;
      o_cursor_store_base  <= 12'h000;
      o_pattern_skip_x     <= 6'h00;
      o_pattern_skip_y     <= 6'h00;
      o_display_start_hi   <= 2'h0;
      o_cpu_base_hi        <= 2'h0;
      o_screen_width_hi    <= 2'h0;
      o_split_transfer_off <= 1'b0;
      o_alpha_pitch_active <= 1'b0;
      o_mmio_reloc_en      <= 1'b0;
      o_mmio_legacy_en     <= 1'b0;
      o_legacy_window_high <= 1'b0;
      o_mem_data_swapped   <= 32'h00000000;
    end
    else
    begin
      o_rdata         <= i_rd ? rdata_nxt : o_rdata;
      o_cursor_on     <= mode_r[`CMX_BIT_ENB] & i_enhanced_mode; // RULE25
      o_cursor_delay  <= {mode_r[`CMX_BIT_CDE], i_seq_delay_lo}; // RULE1
      o_right_storage <= mode_r[`CMX_BIT_RIGHT]; // RULE2
      o_right_2k_line <= mode_r[`CMX_BIT_RIGHT] & i_bpp8; // RULE2
      if (i_wr && (i_index == `CMX_IDX_ORGY_H))
      begin
        o_cursor_left_x <= {orgx_h_r[2:0], orgx_l_r}; // RULE5
        o_cursor_top_y  <= {i_wdata[2:0], orgy_l_r}; // RULE5
      end
      o_fg_color           <= {fg_r[2], fg_r[1], fg_r[0]}; // RULE6
      o_bg_color           <= {bg_r[2], bg_r[1], bg_r[0]}; // RULE7
      o_cursor_store_base  <= {sta_h_r[3:0], sta_l_r}; // RULE9
      o_pattern_skip_x     <= dx_r[5:0]; // RULE10
      o_pattern_skip_y     <= dy_r[5:0]; // RULE11
      o_display_start_hi   <= i_disp_start_ext_used ? 2'h0 : sctl2_r[1:0]; // RULE12
      o_cpu_base_hi        <= i_cpu_base_ext_used ? 2'h0 : sctl2_r[3:2]; // RULE13
      o_screen_width_hi    <= (sctl2_r[5:4] != 2'h0) ? sctl2_r[5:4]
                              : {1'b0, i_old_width_bit8}; // RULE14
      o_split_transfer_off <= sctl2_r[`CMX_BIT_SPLIT]; // RULE15
      o_alpha_pitch_active <= mctl1_r[`CMX_BIT_ALPHA] & i_linear_en
                              & (i_law_size >= `CMX_LAW_2MB); // RULE18
      o_mmio_reloc_en      <= mctl1_r[3]; // RULE20
      o_mmio_legacy_en     <= mctl1_r[4]; // RULE20
      o_legacy_window_high <= (mctl1_r[4:3] == `CMX_MMIO_LEGACY)
                              & mctl1_r[`CMX_BIT_WIN]; // RULE21
      o_mem_data_swapped   <= swapped;
    end
  end

endmodule
`default_nettype wire

// [testbench/cmx_regs_asserts.sv]
// checker for the cursor and memory extension bank
// assumes it is bound onto cmx_regs
`timescale 1ns/1ns
`default_nettype none
module cmx_chk
(
  input wire        i_clk,
  input wire        i_rst,
  input wire [7:0]  i_index,
  input wire        i_wr,
  input wire        i_rd,
  input wire [7:0]  i_wdata,
  input wire [2:0]  i_seq_delay_lo,
  input wire        i_enhanced_mode,
  input wire        i_image_access,
  input wire [31:0] i_mem_data,
  input wire        o_cursor_on,
  input wire [3:0]  o_cursor_delay,
  input wire [10:0] o_cursor_top_y,
  input wire [23:0] o_fg_color,
  input wire [23:0] o_bg_color,
  input wire        o_mmio_reloc_en,
  input wire        o_mmio_legacy_en,
  input wire        o_legacy_window_high,
  input wire [31:0] o_mem_data_swapped
);
// ****
// cycles since reset
// ****
reg [1:0] live_r;
always @(posedge i_clk or posedge i_rst)
begin
  if (i_rst)
    live_r <= 2'h0;
  else if (live_r != 2'h3)
    live_r <= live_r + 2'h1;
end
default clocking cb @(posedge i_clk);
endclocking
default disable iff (i_rst);
sequence s_clr;
  i_rd && i_index == 8'h45;
endsequence
chk_delay_low: assert property (live_r == 2'h3 && $past(i_seq_delay_lo) ==
  $past(i_seq_delay_lo, 2) |-> o_cursor_delay[2:0] == $past(i_seq_delay_lo))
  else $error("cursor delay low bits wrong");
chk_cursor_on: assert property (o_cursor_on |->
  $past(i_enhanced_mode) || $past(i_enhanced_mode, 2))
  else $error("cursor on outside enhanced mode");
chk_pos_hold: assert property (!(i_wr && i_index == 8'h48) |=>
  $stable(o_cursor_top_y))
  else $error("position moved without y high write");
chk_pos_load: assert property (live_r != 2'h0 && i_wr && i_index == 8'h48 |=>
  o_cursor_top_y[10:8] == $past(i_wdata[2:0]))
  else $error("y high not committed");
chk_fg_stack: assert property (s_clr ##1 i_wr && i_index == 8'h4A |->
  ##2 o_fg_color[7:0] == $past(i_wdata, 2))
  else $error("fg entry zero wrong");
chk_bg_share: assert property (s_clr ##1 i_wr && i_index == 8'h4A
  ##1 i_wr && i_index == 8'h4B |-> ##2 o_bg_color[15:8] == $past(i_wdata, 2))
  else $error("bg entry one wrong");
chk_win_sel: assert property (o_legacy_window_high |->
  o_mmio_legacy_en && !o_mmio_reloc_en)
  else $error("window bit active off select 10");
chk_image_pass: assert property (live_r == 2'h3 && $past(i_image_access) |->
  o_mem_data_swapped == $past(i_mem_data))
  else $error("image data altered");
cov_fg: cover property (s_clr ##1 i_wr && i_index == 8'h4A);
cov_win: cover property (o_legacy_window_high);
cov_on: cover property ($rose(o_cursor_on));
endmodule
bind cmx_regs cmx_chk u_chk
(
  .i_clk(i_clk), .i_rst(i_rst), .i_index(i_index), .i_wr(i_wr), .i_rd(i_rd),
  .i_wdata(i_wdata), .i_seq_delay_lo(i_seq_delay_lo), .i_enhanced_mode(i_enhanced_mode),
  .i_image_access(i_image_access), .i_mem_data(i_mem_data), .o_cursor_on(o_cursor_on),
  .o_cursor_delay(o_cursor_delay), .o_cursor_top_y(o_cursor_top_y),
  .o_fg_color(o_fg_color), .o_bg_color(o_bg_color), .o_mmio_reloc_en(o_mmio_reloc_en),
  .o_mmio_legacy_en(o_mmio_legacy_en), .o_legacy_window_high(o_legacy_window_high),
  .o_mem_data_swapped(o_mem_data_swapped)
);
`default_nettype wire

// [testbench/cmx_host.sv]
// host model on the index/data register port
// assumes callers enter its tasks just after a clock edge
`timescale 1ns/1ns
`default_nettype none
module cmx_host
(
  input  wire       i_clk,
  input  wire [7:0] i_rdata,
  output reg  [7:0] o_index,
  output reg        o_wr,
  output reg        o_rd,
  output reg  [7:0] o_wdata
);
initial
begin
  {o_index, o_wr, o_rd, o_wdata} = 18'h00000;
end
task xfer(input wr, input [7:0] ad, input [7:0] dd, output [7:0] q);
  begin
    o_wr = wr;
    o_rd = !wr;
    o_index = ad;
    o_wdata = dd;
    @(posedge i_clk);
    #1 q = i_rdata;
  end
endtask
// released bus shows inverted values
task idle;
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_index = ~o_index;
    o_wdata = ~o_wdata;
    @(posedge i_clk);
    #1;
  end
endtask
endmodule
`default_nettype wire

// [testbench/cmx_regs_tb_top.sv]
// self-checking bench for the extension register bank
// assumes design, checker and host model compiled first
`timescale 1ns/1ns
`default_nettype none
module cmx_regs_tb_top;
reg         clk, rst, enh, bpp8, dext, cext, oldw, len, lin, img;
reg  [2:0]  seq;
reg  [1:0]  law;
reg  [3:0]  be;
reg  [31:0] mem;
reg  [7:0]  m [0:31];
reg  [7:0]  a, d, q;
reg  [23:0] fs, bs;
reg  [21:0] pxy;
reg  [63:0] x;
integer     p, i, cyc, seed, err_count, tests_run;
wire [7:0]  idx, wd, rdata;
wire        wr, rd, on, rs, r2, spl, alp, rel, leg, wh;
wire [3:0]  dly;
wire [10:0] lx, ty;
wire [23:0] fg, bg;
wire [11:0] sb;
wire [5:0]  sx, sy;
wire [1:0]  dsh, cbh, swh;
wire [31:0] msw;
cmx_host h (.i_clk(clk), .i_rdata(rdata), .o_index(idx), .o_wr(wr), .o_rd(rd), .o_wdata(wd));
cmx_regs i_dut
(
  .i_clk(clk), .i_rst(rst), .i_index(idx), .i_wr(wr), .i_rd(rd), .i_wdata(wd),
  .i_seq_delay_lo(seq), .i_enhanced_mode(enh), .i_bpp8(bpp8), .i_disp_start_ext_used(dext),
  .i_cpu_base_ext_used(cext), .i_old_width_bit8(oldw), .i_linear_en(len), .i_law_size(law),
  .i_linear_access(lin), .i_image_access(img), .i_pci_be_n(be), .i_mem_data(mem),
  .o_rdata(rdata), .o_cursor_on(on), .o_cursor_delay(dly), .o_right_storage(rs),
  .o_right_2k_line(r2), .o_cursor_left_x(lx), .o_cursor_top_y(ty), .o_fg_color(fg),
  .o_bg_color(bg), .o_cursor_store_base(sb), .o_pattern_skip_x(sx), .o_pattern_skip_y(sy),
  .o_display_start_hi(dsh), .o_cpu_base_hi(cbh), .o_screen_width_hi(swh),
  .o_split_transfer_off(spl), .o_alpha_pitch_active(alp), .o_mmio_reloc_en(rel),
  .o_mmio_legacy_en(leg), .o_legacy_window_high(wh), .o_mem_data_swapped(msw)
);
initial
begin
  clk = 1'b0;
  forever #20 clk = ~clk;
end
// ****
// expectation helpers
// ****
function [7:0] msk(input [7:0] ad);
  case (ad)
    8'h45: msk = 8'h13;
    8'h46, 8'h48: msk = 8'h07;
    8'h4C: msk = 8'h0F;
    8'h4E, 8'h4F: msk = 8'h3F;
    8'h51, 8'h53: msk = 8'h7F;
    8'h54: msk = 8'h03;
    8'h47, 8'h49, 8'h4D, 8'h52: msk = 8'hFF;
    default: msk = 8'h00;
  endcase
endfunction
function [31:0] sw(input [31:0] dd);
  reg [1:0] c;
  integer   k;
  begin
    c = lin ? m[19][2:1] : m[20][1:0];
    if (c == 2'h3)
      c = lin ? 2'h0 : (be == 4'h0) ? 2'h2 : (be == 4'h3 || be == 4'hC) ? 2'h1 : 2'h0;
    sw = (c == 2'h1) ? {dd[23:16], dd[31:24], dd[7:0], dd[15:8]} :
         (c == 2'h2) ? {dd[7:0], dd[15:8], dd[23:16], dd[31:24]} : dd;
    for (k = 0; k < 4; k = k + 1)
      if (lin && m[19][6])
        sw[k*8+:8] = {sw[k*8+:4], sw[k*8+4+:4]};
    if (img)
      sw = dd;
  end
endfunction
task chk(input string n, input [63:0] e, input [63:0] g);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  end
endtask
task w(input [7:0] ad, input [7:0] dd);
  begin
    h.xfer(1'b1, ad, dd, q);
    m[ad[4:0]] = dd & msk(ad);
    if (ad == 8'h48)
      pxy = {m[6][2:0], m[7], dd[2:0], m[9]};
    if (ad == 8'h4A)
      fs[p*8+:8] = dd;
    if (ad == 8'h4B)
      bs[p*8+:8] = dd;
    if (ad == 8'h4A || ad == 8'h4B)
      p = (p == 2) ? 0 : p + 1;
  end
endtask
task r(input [7:0] ad);
  reg [7:0] e;
  begin
    e = (ad == 8'h4A) ? fs[p*8+:8] : (ad == 8'h4B) ? bs[p*8+:8] : m[ad[4:0]];
    h.xfer(1'b0, ad, 8'h00, q);
    chk("rdata", e, q);
    if (ad == 8'h45)
      p = 0;
  end
endtask
task derive;
  begin
    x = {m[5][0] & enh, m[5][1], seq, m[5][4], m[5][4] & bpp8, m[12][3:0], m[13], m[14][5:0],
         m[15][5:0]};
    chk("cursor", x, {on, dly, rs, r2, sb, sx, sy});
    chk("position", pxy, {lx, ty});
    chk("stack", {fs, bs}, {fg, bg});
    x = {dext ? 2'h0 : m[17][1:0], cext ? 2'h0 : m[17][3:2],
         (m[17][5:4] != 2'h0) ? m[17][5:4] : {1'b0, oldw}, m[17][6], m[19][0] & len & law[1],
         m[19][3], m[19][4], m[19][5] & (m[19][4:3] == 2'h2)};
    chk("memctl", x, {dsh, cbh, swh, spl, alp, rel, leg, wh});
    chk("swap", sw(mem), msw);
  end
endtask
task summarize;
  begin
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
endtask
always @(posedge clk)
begin
  cyc = cyc + 1;
  if (cyc == 5000)
  begin
    err_count = err_count + 1;
    summarize;
  end
end
// ****
// main sequence
// ****
initial
begin
  {seed, err_count, tests_run, cyc, p} = {32'd34, 128'd0};
  {rst, enh, bpp8, dext, cext, oldw, len, lin, img, seq, law, be, mem} = {1'b1, 49'd0};
  {fs, bs, pxy} = 70'd0;
  for (i = 0; i < 32; i = i + 1)
    m[i] = 8'h00;
  m[19] = 8'h08;
  repeat (10) @(posedge clk);
  #1 rst = 1'b0;
  for (a = 8'h45; a != 8'h55; a = a + 8'h01)
    r(a);
  for (i = 0; i < 40; i = i + 1)
  begin
    {seq, enh, bpp8, dext, cext, oldw, len, law} = $random(seed);
    mem = $random(seed);
    lin = i[2];
    img = (i % 7 == 6);
    be = (i[1:0] == 2'h0) ? 4'h0 : (i[1:0] == 2'h1) ? 4'h3 : (i[1:0] == 2'h2) ? 4'hC : $random(seed);
    r(8'h45);
    repeat (4) w(8'h4A + ($random(seed) & 1), $random(seed));
    for (a = 8'h45; a != 8'h55; a = a + 8'h01)
    begin
      d = $random(seed);
      if (a == 8'h4D && m[5][4]) d[1:0] = 2'h3;
      if (a == 8'h51 && enh) d[6] = 1'b0;
      if (a == 8'h53) d[2:1] = i[4:3];
      if (a == 8'h54) d[1:0] = i[4:3];
      if (a != 8'h4A && a != 8'h4B) w(a, d);
    end
    r(8'h4A);
    r(8'h4B);
    h.idle;
    h.idle;
    derive;
    r(8'h45 + ($random(seed) & 15));
  end
  summarize;
end
endmodule
`default_nettype wire
